// [hdl/cvc_pkg.sv]
// package for the comparator and reference ladder control block
// assumes one clock domain and a single-word AHB-Lite register slave
package cvc_pkg;

	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] CVC_OFF_CMP = 8'h00;
	localparam logic [7:0] CVC_OFF_LAD = 8'h04;
	localparam logic [7:0] CVC_OFF_STAT = 8'h08;
	localparam logic [7:0] CVC_OFF_MASK = 8'h0C;
	localparam logic [7:0] CVC_OFF_SLEEP = 8'h10;
	localparam logic [7:0] CVC_OFF_OUTS = 8'h14;
	localparam int CVC_NREG = 6;

	// ==========================================
	// comparator control fields
	localparam int CVC_CMP_SECOND_COMPARATOR_RESULT = 7;
	localparam int CVC_CMP_FIRST_COMPARATOR_RESULT = 6;
	localparam logic [7:0] CVC_CMP_WMASK = 8'h3F;
	localparam logic [2:0] CVC_MODE_OFF = 3'h7;
	localparam logic [2:0] CVC_MODE_MUX4_VREF = 3'h6;
	localparam logic [7:0] CVC_CMP_RST = 8'h07;

	// ==========================================
	// ladder control fields
	localparam int CVC_LAD_EN = 7;
	localparam int CVC_LAD_OE = 6;
	localparam int CVC_LAD_RNG = 5;
	localparam int CVC_LAD_SRC = 4;
	localparam logic [7:0] CVC_LAD_RST = 8'h00;

	// ==========================================
	// status / mask bits
	localparam int CVC_ST_CHG = 0;
	localparam int CVC_ST_W = 1;

	typedef struct packed {
		logic c2inv;
		logic c1inv;
		logic cis;
		logic [2:0] mode;
	} cvc_cmp_t;

	typedef struct packed {
		logic power_on;
		logic pin_drive;
		logic range_sel;
		logic source_sel;
		logic [3:0] tap;
	} cvc_lad_t;

	// analog-facing control bundle
	typedef struct packed {
		logic cmp1_on;
		logic cmp2_on;
		logic vref_to_cmp;
		logic ladder_power_on;
		logic ladder_pin_drive;
		logic ladder_range_select;
		logic ladder_source_select;
		logic [3:0] ladder_tap_code;
	} cvc_ana_t;

	function automatic logic [7:0] cvc_hit(input logic [7:0] a);
		logic [7:0] h;
		h = '0;
		case (a)
			CVC_OFF_CMP: h[0] = 1'b1;
			CVC_OFF_LAD: h[1] = 1'b1;
			CVC_OFF_STAT: h[2] = 1'b1;
			CVC_OFF_MASK: h[3] = 1'b1;
			CVC_OFF_SLEEP: h[4] = 1'b1;
			CVC_OFF_OUTS: h[5] = 1'b1;
			default: h = '0;
		endcase
		return h;
	endfunction

endpackage

// [hdl/cvc_sync.sv]
// two-flop synchroniser for asynchronous comparator outputs
// assumes the analog side toggles slower than the clock
`timescale 1ns/1ns
module cvc_sync #(
	parameter int W = 2
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} cvc_sync_st_t;

	cvc_sync_st_t st_r;
	cvc_sync_st_t st_nxt;

	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule

// [hdl/cvc_top.sv]
// comparator mode and reference ladder control with AHB-Lite registers
// assumes the analog comparators and ladder sit outside; results arrive async
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module cvc_top
	import cvc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] comparator_raw,
	input wire logic sleeping,
	input wire logic port_a_direction_two,
	output cvc_ana_t ana,
	output logic port_a_pin_two_digital_oe,
	output logic comparator_change_flag,
	output logic irq,
	output logic wake_request
);

	// ==========================================
	// state
	typedef struct packed {
		cvc_cmp_t cmp;
		cvc_lad_t lad;
		logic [1:0] latched;
		logic [CVC_ST_W-1:0] status;
		logic [CVC_ST_W-1:0] mask;
		logic wr_pend;
		logic [7:0] wr_hit;
		logic [31:0] rdata;
		cvc_ana_t ana;
	} cvc_st_t;

	cvc_st_t st_r;
	cvc_st_t st_nxt;
	logic [1:0] res_sync;
	logic [1:0] res_shown;
	logic addr_valid;
	logic [7:0] hit;
	logic access_cmp;
	logic mismatch;
	logic irq_lvl;

	// ==========================================
	// synchronise analog results
	cvc_sync #(
		.W(2)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(comparator_raw),
		.q(res_sync)
	);

	// ==========================================
	// helpers
	function automatic cvc_ana_t make_ana(input cvc_cmp_t c, input cvc_lad_t l);
		cvc_ana_t a;
		a.cmp1_on = (c.mode != CVC_MODE_OFF);
		a.cmp2_on = (c.mode != CVC_MODE_OFF);
		a.vref_to_cmp = (c.mode == CVC_MODE_MUX4_VREF);
		// ladder fields pass straight through, no dependence on mode
		a.ladder_power_on = l.power_on;
		a.ladder_pin_drive = l.pin_drive;
		a.ladder_range_select = l.range_sel;
		a.ladder_source_select = l.source_sel;
		a.ladder_tap_code = l.tap;
		return a;
	endfunction

	function automatic logic [7:0] cmp_byte(input cvc_cmp_t c, input logic [1:0] r);
		return {r[1], r[0], c};
	endfunction

	// ==========================================
	// bus decode
	assign addr_valid = hsel && hready && htrans[1];
	assign hit = cvc_hit(haddr);
	// a read or a write address phase of comparator control resyncs the latch
	assign access_cmp = addr_valid && hit[0];

	// comparator outputs forced low while both are off
	assign res_shown = (st_r.cmp.mode == CVC_MODE_OFF) ? 2'b00 : res_sync;
	assign mismatch = (res_shown != st_r.latched);

	always_comb begin
		st_nxt = st_r;

		// write data phase: fields update next cycle
		st_nxt.wr_pend = 1'b0;
		st_nxt.wr_hit = '0;
		if (st_r.wr_pend) begin
			if (st_r.wr_hit[0]) begin
				// result bits 7:6 masked off; writes never reach them
				st_nxt.cmp = cvc_cmp_t'(hwdata[7:0] & CVC_CMP_WMASK);
			end
			if (st_r.wr_hit[1]) begin
				st_nxt.lad = cvc_lad_t'(hwdata[7:0]);
			end
			if (st_r.wr_hit[3]) begin
				st_nxt.mask = hwdata[CVC_ST_W-1:0];
			end
		end

		// ---- address phase capture
		if (addr_valid && hwrite) begin
			st_nxt.wr_pend = 1'b1;
			st_nxt.wr_hit = hit;
		end

		// ---- read data, registered
		st_nxt.rdata = '0;
		if (addr_valid && !hwrite) begin
			case (1'b1)
				hit[0]: st_nxt.rdata = {24'h0000_00, cmp_byte(st_r.cmp, res_shown)};
				hit[1]: st_nxt.rdata = {24'h0000_00, st_r.lad};
				hit[2]: st_nxt.rdata = {31'h0000_0000, st_r.status[CVC_ST_CHG]};
				hit[3]: st_nxt.rdata = {31'h0000_0000, st_r.mask[CVC_ST_CHG]};
				hit[4]: st_nxt.rdata = {31'h0000_0000, sleeping};
				hit[5]: st_nxt.rdata = {30'h0000_0000, res_shown};
				default: st_nxt.rdata = '0;
			endcase
		end

		// change detection: a read or write access to comparator control ends the mismatch
		if (access_cmp) begin
			st_nxt.latched = res_shown;
		end

		// sticky flag, write one to clear; a new mismatch wins
		if (st_r.wr_pend && st_r.wr_hit[2] && hwdata[CVC_ST_CHG]) begin
			st_nxt.status[CVC_ST_CHG] = 1'b0;
		end
		if (mismatch) begin
			st_nxt.status[CVC_ST_CHG] = 1'b1;
		end

		// sleep state is never consulted for the analog controls
		st_nxt.ana = make_ana(st_nxt.cmp, st_nxt.lad);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.cmp <= cvc_cmp_t'(CVC_CMP_RST);
			st_r.lad <= cvc_lad_t'(CVC_LAD_RST);
			st_r.latched <= '0;
			st_r.status <= '0;
			st_r.mask <= '0;
			st_r.wr_pend <= 1'b0;
			st_r.wr_hit <= '0;
			st_r.rdata <= '0;
			st_r.ana <= '0; // comparators off, ladder down, pin released
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================
	// outputs
	assign hrdata = st_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign ana = st_r.ana;
	// ladder on the pin overrides the port direction: digital driver released
	assign port_a_pin_two_digital_oe = !st_r.lad.pin_drive && !port_a_direction_two;
	assign comparator_change_flag = st_r.status[CVC_ST_CHG];
	assign irq_lvl = |(st_r.status & st_r.mask);
	assign irq = irq_lvl;
	// comparators keep running in sleep, so an unmasked change still wakes
	assign wake_request = irq_lvl && sleeping;
	// software is expected to drop ladder power before sleep; hardware keeps it

endmodule

// [tb/cvc_top_asserts.sv]
// concurrent checks on the ports of cvc_top
// assumes one clock hclk, async active-low hresetn, zero-wait slave
`timescale 1ns/1ns
module cvc_top_asserts
	import cvc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic sleeping,
	input wire logic port_a_direction_two,
	input cvc_ana_t ana,
	input wire logic port_a_pin_two_digital_oe,
	input wire logic irq,
	input wire logic wake_request
);
	// ==========
	// data phase tracking
	logic ap_r;
	logic wr_r;
	logic [7:0] addr_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_r <= 1'b0;
			wr_r <= 1'b0;
			addr_r <= 8'h00;
		end else begin
			ap_r <= hsel && hready && htrans[1];
			wr_r <= hwrite;
			addr_r <= haddr;
		end
	end
	wire cw = ap_r && wr_r && addr_r == CVC_OFF_CMP;
	wire rd = ap_r && !wr_r;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_off;
		cw && hwdata[2:0] == CVC_MODE_OFF |=> !ana.cmp1_on && !ana.cmp2_on;
	endproperty
	a_off: assert property (p_off) else $error("comparator on in off mode");
	property p_vref;
		cw |=> ana.vref_to_cmp == (3'($past(hwdata)) == CVC_MODE_MUX4_VREF);
	endproperty
	a_vref: assert property (p_vref) else $error("ladder routing wrong");
	property p_lad;
		ap_r && wr_r && addr_r == CVC_OFF_LAD |=> ana[7:0] == 8'($past(hwdata));
	endproperty
	a_lad: assert property (p_lad) else $error("ladder fields wrong");
	property p_hold;
		!(ap_r && wr_r) |=> $stable(ana);
	endproperty
	a_hold: assert property (p_hold) else $error("controls moved");
	property p_oe;
		port_a_pin_two_digital_oe == (!ana.ladder_pin_drive && !port_a_direction_two);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable wrong");
	property p_wake;
		wake_request == (irq && sleeping);
	endproperty
	a_wake: assert property (p_wake) else $error("wake wrong");
	property p_rdlad;
		rd && addr_r == CVC_OFF_LAD |-> hrdata == {24'h00_0000, ana[7:0]};
	endproperty
	a_rdlad: assert property (p_rdlad) else $error("ladder readback wrong");
	property p_unmap;
		rd && addr_r > CVC_OFF_OUTS |-> hrdata == 32'h0000_0000;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
endmodule
bind cvc_top cvc_top_asserts chk_u(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hrdata, .sleeping, .port_a_direction_two, .ana, .port_a_pin_two_digital_oe,
	.irq, .wake_request);

// [tb/cvc_top_bench.sv]
// self-checking bench: AHB-Lite master tasks, register model, compares
// assumes cvc_pkg compiled first; hready is fed from hreadyout
`timescale 1ns/1ns
module cvc_top_bench;
	import cvc_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleeping = 1'b0;
	logic port_a_direction_two = 1'b1;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0, comparator_raw = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0, hrdata, rd_s, q, lf = 32'h534d_e3bf;
	logic hready, hreadyout, hresp, port_a_pin_two_digital_oe, comparator_change_flag;
	logic irq, wake_request;
	logic [7:0] cm, ld;
	cvc_ana_t ana;
	int mismatches = 0;
	int total_checks = 0;
	assign hready = hreadyout;
	cvc_top dut_u(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .comparator_raw, .sleeping, .port_a_direction_two, .ana,
		.port_a_pin_two_digital_oe, .comparator_change_flag, .irq, .wake_request);
	// captured before the edge updates land, so read data is race-free
	always @(posedge hclk) rd_s <= hrdata;
	initial begin
		forever #50 hclk = ~hclk;
	end
	// one step of the stimulus generator; taps give a long sequence from the seed
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		if (n >= 64) begin
			mismatches++;
			summarize();
		end
	endtask
	task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		#1 q = rd_s;
	endtask
	task automatic ck();
		chk({23'h0, ana[8:0]}, {23'h0, cm[2:0] == CVC_MODE_MUX4_VREF, ld});
		chk({30'h0, ana[10:9]}, (cm[2:0] == CVC_MODE_OFF) ? 32'h0000_0000 : 32'h0000_0003);
	endtask
	task automatic rst();
		hresetn <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		cm = CVC_CMP_RST;
		ld = CVC_LAD_RST;
		xf(CVC_OFF_CMP, 1'b0, '0);
		chk(q, {24'h0, cm});
		xf(CVC_OFF_LAD, 1'b0, '0);
		chk(q, {24'h0, ld});
		ck();
	endtask
	initial begin
		rst();
		for (int i = 0; i < 8; i++) begin
			lf = lfsr(lf);
			cm = {4'h0, lf[3], 3'(i)};
			ld = lf[15:8];
			sleeping <= lf[16];
			port_a_direction_two <= lf[17];
			xf(CVC_OFF_CMP, 1'b1, {lf[31:8], 4'hC, cm[3:0]});
			xf(CVC_OFF_LAD, 1'b1, {24'h0, ld});
			ck();
			chk({31'h0, port_a_pin_two_digital_oe}, {31'h0, !ld[6] && !port_a_direction_two});
			xf(CVC_OFF_CMP, 1'b0, '0);
			chk(q, {24'h0, cm});
			xf(CVC_OFF_LAD, 1'b0, '0);
			chk(q, {24'h0, ld});
		end
		// the loop ends in the off mode, which hides results; turn comparators on
		cm = 8'h00;
		xf(CVC_OFF_CMP, 1'b1, 32'h0000_0000);
		xf(CVC_OFF_MASK, 1'b1, 32'h0000_0001);
		sleeping <= 1'b1;
		comparator_raw <= 2'h1;
		repeat (4) @(posedge hclk);
		#1;
		chk({30'h0, irq, wake_request}, 32'h0000_0003);
		xf(CVC_OFF_STAT, 1'b1, 32'h0000_0001);
		xf(CVC_OFF_STAT, 1'b0, '0);
		chk(q, 32'h0000_0001);
		xf(CVC_OFF_CMP, 1'b0, '0);
		xf(CVC_OFF_STAT, 1'b1, 32'h0000_0001);
		xf(CVC_OFF_STAT, 1'b0, '0);
		chk(q, '0);
		chk({31'h0, irq}, '0);
		xf(CVC_OFF_MASK, 1'b1, '0);
		comparator_raw <= 2'h0;
		repeat (4) @(posedge hclk);
		#1;
		chk({30'h0, comparator_change_flag, irq}, 32'h0000_0002);
		xf(8'h1C, 1'b1, 32'hFFFF_FFFF);
		xf(8'h1C, 1'b0, '0);
		chk(q, '0);
		rst();
		summarize();
	end
endmodule
